/* File: hdl/switch_ctrl_pkg.sv */
// constants shared by the octal switch control design
// assumes a 250 MHz system clock and an SPI master on the link
package switch_ctrl_pkg;

    localparam int unsigned CHANNELS           = 8;
    localparam int unsigned SERIAL_CHANNELS    = 6;
    localparam int unsigned FRAME_BYTE_BITS    = 8;
    localparam int unsigned RX_BITS            = 8;
    localparam int unsigned BIT_IDX_W          = 4;

    localparam logic [BIT_IDX_W-1:0] BIT_IDX_RESET  = 4'h0;
    localparam logic [BIT_IDX_W-1:0] BIT_IDX_ONE    = 4'h1;
    localparam logic [BIT_IDX_W-1:0] BIT_IDX_ECHO   = 4'h8;
    localparam logic [2:0]           BYTE_MSB       = 3'h7;
    localparam int unsigned          RX_ECHO_BIT    = 7;

    localparam logic [7:0] CMD_RESET          = 8'h00;
    localparam logic [7:0] STATUS_RESET       = 8'h00;
    localparam logic [7:0] OUTPUTS_OFF        = 8'h00;
    localparam logic [1:0] LOW_POWER_OFF      = 2'h0;

    // command byte field layout
    localparam int unsigned CMD_CHAN_MSB      = 5;
    localparam int unsigned CMD_OLE_LSB       = 6;
    localparam int unsigned CMD_OLE_MSB       = 7;

    // timing
    localparam int unsigned SYS_CLK_PERIOD_NS = 4;
    localparam int unsigned OPEN_LOAD_TIME_NS = 100000;
    localparam int unsigned OPEN_LOAD_CYCLES  =
        (OPEN_LOAD_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

endpackage : switch_ctrl_pkg

/* File: hdl/bit_sync.sv */
// two flip-flop level synchroniser, one per bit
// assumes inputs are levels from outside the sys_clk domain
`timescale 1ns/1ps
module bit_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb
    begin
        next_meta = d_i;
        next_q    = meta;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta <= INIT;
            q_o  <= INIT;
        end
        else
        begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end

endmodule : bit_sync

/* File: hdl/open_load_filter.sv */
// per-channel qualifier: output rises only after input held for CYCLES
// assumes a synchronised raw open-load indication per channel
`timescale 1ns/1ps
module open_load_filter #(
    parameter int unsigned CHANNELS = 8,
    parameter int unsigned CYCLES   = 25000,
    parameter int unsigned CNT_W    = $clog2(CYCLES + 1)
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // indications
    input  wire logic [CHANNELS-1:0] raw_i,
    output logic      [CHANNELS-1:0] qualified_o
);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        logic [CNT_W-1:0] held;
        logic [CNT_W-1:0] next_held;

        // a short blip restarts the count
        always_comb
        begin
            if (!raw_i[ch])
                next_held = CNT_ZERO;
            else if (held == CNT_FULL)
                next_held = held;
            else
                next_held = held + CNT_ONE;
        end

        always_ff @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
                held <= CNT_ZERO;
            else
                held <= next_held;
        end

        assign qualified_o[ch] = (held == CNT_FULL);
    end

endmodule : open_load_filter

/* File: hdl/octal_switch_spi_control.sv */
// control logic of an eight channel low-side switch driver
// assumes an SPI master drives sclk_i, cs_n_i and si_i; fault sensing
// arrives as digital levels; so_o/so_oe_o resolved by a pull-up outside
`timescale 1ns/1ps
module octal_switch_spi_control
    import switch_ctrl_pkg::*;
#(
    parameter int unsigned OPEN_LOAD_FILTER_CYCLES = switch_ctrl_pkg::OPEN_LOAD_CYCLES
) (
    // system clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // serial link
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    output logic            so_o,
    output logic            so_oe_o,
    // mode and parallel control pins
    input  wire logic       mode_n_i,
    input  wire logic [7:0] parallel_channel_inputs_i,
    input  wire logic       pair_control_input_a_i,
    input  wire logic       pair_control_input_b_i,
    input  wire logic       pair_control_input_c_i,
    input  wire logic       over_voltage_i,
    // fault sensing
    input  wire logic [7:0] short_fault_i,
    input  wire logic [7:0] open_load_i,
    // gate drives and status
    output logic      [7:0] channel_switch_outputs_o,
    output logic      [1:0] on_open_load_enable_bits_o,
    output logic      [7:0] fault_status_o
);
    import switch_ctrl_pkg::*;

    // link domain: shift register, bit index, echo bit
    logic                 frame_idle;
    logic [RX_BITS-1:0]   rx_shift;
    logic [RX_BITS-1:0]   next_rx_shift;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [BIT_IDX_W-1:0] next_bit_idx;
    logic                 echo_bit;
    logic                 next_echo_bit;
    logic [RX_BITS-1:0]   rx_hold;
    logic [RX_BITS-1:0]   next_rx_hold;

    // sys domain state
    logic [7:0]           status;
    logic [7:0]           next_status;
    logic [7:0]           cmd;
    logic [7:0]           next_cmd;
    logic [7:0]           gates;
    logic [7:0]           next_gates;
    logic                 cs_n_prev;
    logic                 next_cs_n_prev;

    // synchronised pins
    logic                 cs_n_s;
    logic                 mode_n_s;
    logic                 ov_s;
    logic [7:0]           par_s;
    logic [2:0]           pair_s;
    logic [7:0]           short_s;
    logic [7:0]           open_s;
    logic [7:0]           open_q;
    logic                 frame_end;
    logic [7:0]           fault_now;

    // bit index and echo bit are held in reset outside a frame, so no stray edge counts
    assign frame_idle = cs_n_i | rst_i;

    // rising sclk: shift in MSB first, older bits move toward the echo
    always_comb
    begin
        next_rx_shift = {rx_shift[RX_BITS-2:0], si_i};
    end

    // power-up clear only; a frame end must not wipe the received byte
    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
            rx_shift <= CMD_RESET;
        else
            rx_shift <= next_rx_shift;
    end

    // select rise: hold the received byte for the sys domain
    always_comb
    begin
        next_rx_hold = rx_shift;
    end

    always_ff @(posedge cs_n_i or posedge rst_i)
    begin
        if (rst_i)
            rx_hold <= CMD_RESET;
        else
            rx_hold <= next_rx_hold;
    end

    // falling sclk: advance the output bit index
    always_comb
    begin
        if (bit_idx == BIT_IDX_ECHO)
            next_bit_idx = bit_idx;
        else
            next_bit_idx = bit_idx + BIT_IDX_ONE;
    end

    always_ff @(negedge sclk_i or posedge frame_idle)
    begin
        if (frame_idle)
            bit_idx <= BIT_IDX_RESET;
        else
            bit_idx <= next_bit_idx;
    end

    // falling sclk: capture the bit that falls out of the receive byte
    always_comb
    begin
        next_echo_bit = rx_shift[RX_ECHO_BIT];
    end

    always_ff @(negedge sclk_i or posedge frame_idle)
    begin
        if (frame_idle)
            echo_bit <= 1'b0;
        else
            echo_bit <= next_echo_bit;
    end

    // status word is frozen for the whole frame, so it is quasi-static here
    always_comb
    begin
        if (bit_idx < BIT_IDX_ECHO)
            so_o = status[BYTE_MSB - bit_idx[2:0]];
        else
            so_o = echo_bit;
    end

    // released otherwise; an external pull-up then yields all ones
    assign so_oe_o = ~cs_n_i & ~mode_n_i;

    // pin synchronisers
    bit_sync #(
        .WIDTH (3),
        .INIT  (3'h7)
    ) u_sync_ctrl (
        .clk_i (sys_clk_i),
        .rst_i (rst_i),
        .d_i   ({cs_n_i, mode_n_i, over_voltage_i}),
        .q_o   ({cs_n_s, mode_n_s, ov_s})
    );

    bit_sync #(
        .WIDTH (27),
        .INIT  (27'h0)
    ) u_sync_data (
        .clk_i (sys_clk_i),
        .rst_i (rst_i),
        .d_i   ({parallel_channel_inputs_i,
                 pair_control_input_c_i, pair_control_input_b_i, pair_control_input_a_i,
                 short_fault_i, open_load_i}),
        .q_o   ({par_s, pair_s, short_s, open_s})
    );

    open_load_filter #(
        .CHANNELS (CHANNELS),
        .CYCLES   (OPEN_LOAD_FILTER_CYCLES)
    ) u_open_filter (
        .clk_i       (sys_clk_i),
        .rst_i       (rst_i),
        .raw_i       (open_s),
        .qualified_o (open_q)
    );

    // select rise seen in the sys domain ends the frame
    always_comb
    begin
        frame_end = cs_n_s & ~cs_n_prev;
        fault_now = short_s | open_q;
    end

    // select edge detector, idle level high so reset gives no false edge
    always_comb
    begin
        next_cs_n_prev = cs_n_s;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cs_n_prev <= 1'b1;
        else
            cs_n_prev <= next_cs_n_prev;
    end

    // fault register: frozen in a frame, read clears, set wins
    always_comb
    begin
        if (!cs_n_s)
            next_status = status;
        else if (frame_end)
            next_status = fault_now;
        else
            next_status = status | fault_now;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            status <= STATUS_RESET;
        else
            status <= next_status;
    end

    // command latch: takes the held byte once per frame end
    always_comb
    begin
        next_cmd = cmd;
        if (frame_end)
            next_cmd = rx_hold;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cmd <= CMD_RESET;
        else
            cmd <= next_cmd;
    end

    // gate drive selection, one slice per channel
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_gate
        if (ch < SERIAL_CHANNELS)
        begin : g_serial
            // pair input index of this channel
            localparam int unsigned PAIR = ch / 2;

            always_comb
            begin
                if (ov_s)
                    next_gates[ch] = 1'b0;
                else if (mode_n_s)
                    next_gates[ch] = pair_s[PAIR];
                else
                    next_gates[ch] = cmd[ch] | par_s[ch];
            end
        end
        else
        begin : g_low_power
            always_comb
            begin
                if (ov_s)
                    next_gates[ch] = 1'b0;
                else if (mode_n_s)
                    next_gates[ch] = 1'b0;
                else
                    next_gates[ch] = par_s[ch];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            gates <= OUTPUTS_OFF;
        else
            gates <= next_gates;
    end

    // outputs straight from registers
    assign channel_switch_outputs_o   = gates;
    assign on_open_load_enable_bits_o = cmd[CMD_OLE_MSB:CMD_OLE_LSB];
    assign fault_status_o             = status;

endmodule : octal_switch_spi_control

/* File: dv/spi_host_model.sv */
// host side serial master model for the switch control bench
// assumes so_i is the resolved serial out line, pulled up when released
`timescale 1ns/1ps
module spi_host_model (
    // serial link
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // one frame of n bits, 80 ns bit clock, msb first
    task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        #7;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            si_o = tx[i];
            #40;
            sclk_o = 1'b1;
            rx = {rx[14:0], so_i};
            #40;
            sclk_o = 1'b0;
        end
        #40;
        cs_n_o = 1'b1;
        si_o   = ~si_o;
        #40;
    endtask : xfer
endmodule : spi_host_model

/* File: dv/octal_switch_spi_control_checker.sv */
// port level checks of the switch control block
// assumes binding into the top module, sys_clk_i domain
`timescale 1ns/1ps
module octal_switch_spi_control_checker (
    // clock, reset, link
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       cs_n_i,
    input wire logic       so_oe_o,
    // control pins and results
    input wire logic       mode_n_i,
    input wire logic       over_voltage_i,
    input wire logic       pair_control_input_a_i,
    input wire logic       pair_control_input_b_i,
    input wire logic       pair_control_input_c_i,
    input wire logic [7:0] parallel_channel_inputs_i,
    input wire logic [7:0] short_fault_i,
    input wire logic [7:0] channel_switch_outputs_o,
    input wire logic [7:0] fault_status_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence pairs_held;
        (mode_n_i && !over_voltage_i && $stable({pair_control_input_a_i, pair_control_input_b_i,
            pair_control_input_c_i})) [*4];
    endsequence
    sequence normal_held;
        (!mode_n_i && !over_voltage_i && $stable(parallel_channel_inputs_i)) [*4];
    endsequence
    sequence idle_held;
        (cs_n_i && $stable(short_fault_i)) [*6];
    endsequence

    so_enable_a: assert property (so_oe_o == (!cs_n_i && !mode_n_i)) else $error("so enable wrong");
    ov_off_a: assert property (over_voltage_i [*4] |=> channel_switch_outputs_o == 8'h00)
        else $error("gates on in over-voltage");
    six_seven_off_a: assert property (mode_n_i [*4] |=> channel_switch_outputs_o[7:6] == 2'h0)
        else $error("six or seven on in default mode");
    pair_drive_a: assert property (pairs_held |=> channel_switch_outputs_o[5:0] ==
        {{2{$past(pair_control_input_c_i)}}, {2{$past(pair_control_input_b_i)}}, {2{$past(pair_control_input_a_i)}}})
        else $error("pair drive wrong");
    six_seven_par_a: assert property (normal_held |=> channel_switch_outputs_o[7:6] ==
        $past(parallel_channel_inputs_i[7:6])) else $error("six or seven not parallel");
    par_or_a: assert property (normal_held |=> (channel_switch_outputs_o[5:0] & $past(parallel_channel_inputs_i[5:0]))
        == $past(parallel_channel_inputs_i[5:0])) else $error("parallel pin not ored");
    status_frozen_a: assert property (!cs_n_i [*5] |=> $stable(fault_status_o))
        else $error("status moved in frame");
    fault_sticky_a: assert property (cs_n_i [*8] |=> (fault_status_o & $past(fault_status_o)) ==
        $past(fault_status_o)) else $error("fault bit lost");
    fault_set_a: assert property (idle_held |=> (fault_status_o & $past(short_fault_i)) == $past(short_fault_i))
        else $error("fault not recorded");
endmodule : octal_switch_spi_control_checker

bind octal_switch_spi_control octal_switch_spi_control_checker u_checker (.sys_clk_i, .rst_i, .cs_n_i,
    .so_oe_o, .mode_n_i, .over_voltage_i, .pair_control_input_a_i, .pair_control_input_b_i,
    .pair_control_input_c_i, .parallel_channel_inputs_i, .short_fault_i, .channel_switch_outputs_o,
    .fault_status_o);

/* File: dv/octal_switch_spi_control_test.sv */
// self-checking bench for the switch control block
// assumes the host model drives the link and so has a pull-up
`timescale 1ns/1ps
module octal_switch_spi_control_test;
    import switch_ctrl_pkg::*;
    localparam int unsigned OL_CYCLES = 8;
    logic        clk = 1'b0;
    logic        rst, sclk, cs_n, si, so, so_oe, mode_n, pa, pb, pc, ov;
    logic [7:0]  par, sf, ol, gates, fstat;
    logic [1:0]  ole;
    logic [31:0] seed = 32'h0000004d;
    logic [31:0] r;
    int          cmd, stat, failures, total_checks;
    wire         so_line = so_oe ? so : 1'b1;

    always #2 clk = ~clk;

    octal_switch_spi_control #(.OPEN_LOAD_FILTER_CYCLES(OL_CYCLES)) u_dut (.sys_clk_i(clk), .rst_i(rst),
        .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .mode_n_i(mode_n),
        .parallel_channel_inputs_i(par), .pair_control_input_a_i(pa), .pair_control_input_b_i(pb),
        .pair_control_input_c_i(pc), .over_voltage_i(ov), .short_fault_i(sf), .open_load_i(ol),
        .channel_switch_outputs_o(gates), .on_open_load_enable_bits_o(ole), .fault_status_o(fstat));
    spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_line));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] exp_gates();
        if (ov)
            return 8'h00;
        if (mode_n)
            return {2'h0, {2{pc}}, {2{pb}}, {2{pa}}};
        return {par[7:6], par[5:0] | 6'(cmd)};
    endfunction : exp_gates

    task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : compare

    task automatic check_ports();
        repeat (8) @(posedge clk);
        compare(16'(gates), 16'(exp_gates()), "gates");
        compare(16'(ole), 16'(cmd[7:6]), "enables");
        compare(16'(fstat), 16'(stat[7:0]), "status");
    endtask : check_ports

    task automatic frame(input int n, input logic [15:0] tx);
        logic [15:0] rx;
        logic [7:0]  hi;
        host.xfer(n, tx, rx);
        hi = mode_n ? 8'hff : 8'(stat);
        compare(rx, (n == 16) ? {hi, mode_n ? 8'hff : tx[15:8]} : {8'h00, hi}, "serial");
        cmd = int'(tx[7:0]);
        stat = int'(sf);
        check_ports();
    endtask : frame

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        complete_run();
    end

    initial
    begin
        {rst, mode_n, pa, pb, pc, ov, par, sf, ol} = {6'h20, 24'h000000};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        check_ports();
        for (int k = 0; k < 12; k++)
        begin
            r = rnd();
            @(posedge clk);
            par <= r[7:0] & r[15:8];
            frame(k[0] ? 16 : 8, r[31:16]);
        end
        $display("normal frames done");
        @(posedge clk);
        sf <= 8'h81;
        repeat (5) @(posedge clk);
        {sf, ol} <= 16'h0024;
        repeat (3) @(posedge clk);
        ol <= 8'h10;
        repeat (30) @(posedge clk);
        ol <= 8'h00;
        stat = 32'h00000091;
        check_ports();
        frame(8, 16'h00c3);
        frame(16, 16'h5a3c);
        $display("fault frames done");
        @(posedge clk);
        mode_n <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            r = rnd();
            @(posedge clk);
            {pc, pb, pa, par} <= {k[2:0], r[7:0]};
            frame(8, r[23:8]);
        end
        @(posedge clk);
        mode_n <= 1'b0;
        check_ports();
        $display("default mode done");
        @(posedge clk);
        ov <= 1'b1;
        frame(8, 16'h003f);
        $display("over-voltage done");
        complete_run();
    end
endmodule : octal_switch_spi_control_test
